//--- led_behavior_cfg.svh
// Offsets, field positions, reset values and timing counts for the LED behavior block
`ifndef LED_BEHAVIOR_CFG_SVH
`define LED_BEHAVIOR_CFG_SVH

// Register offsets
`define OFF_PAIRING       8'h80
`define OFF_BEHAV_LOW     8'h81
`define OFF_BEHAV_MID     8'h82
`define OFF_BEHAV_HIGH    8'h83
`define OFF_PULSE1_PER    8'h84
`define OFF_PULSE2_PER    8'h85
`define OFF_BREATHE_PER   8'h86
`define OFF_LED_CONFIG    8'h88
`define OFF_DRIVE_LOW     8'hA0
`define OFF_DRIVE_HIGH    8'hA1
`define OFF_POL_LOW       8'hA2
`define OFF_POL_HIGH      8'hA3
`define OFF_INPUT_LOW     8'hA4
`define OFF_INPUT_HIGH    8'hA5
`define OFF_POWER_CTL     8'hA6
`define OFF_ACTIVE_LOW    8'hA7
`define OFF_ACTIVE_HIGH   8'hA8

// Reset values
`define RST_ZERO          8'h00
`define RST_PULSE1_PER    8'h20
`define RST_PULSE2_PER    8'h14
`define RST_BREATHE_PER   8'h5D
`define RST_LED_CONFIG    8'h24

// Field positions
`define POS_SLEEP_ALT     6
`define POS_P2_CNT        3
`define POS_P1_CNT        0
`define POS_ST_TRIG       7
`define POS_PWR_OPTION    0
`define POS_SLEEP         1
`define POS_DEEP_SLEEP_CTL        2

// Timing: one period count is 32 ms at 100 MHz
`define STEP_MS           32
`define CLK_MHZ           100
`define STEP_CYCLES       (`STEP_MS * 1000 * `CLK_MHZ)

`endif

//--- led_behavior_pkg.sv
// Types shared by the LED behavior block
package led_behavior_pkg;
    // Behavior field encodings
    typedef enum logic [1:0] {
        BEH_DIRECT  = 2'h0,
        BEH_PULSE1  = 2'h1,
        BEH_PULSE2  = 2'h2,
        BEH_BREATHE = 2'h3
    } behavior_t;

    // Per-channel run state, one-hot
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_RUN   = 4'h2,
        ST_TAIL  = 4'h4,
        ST_DONE  = 4'h8
    } chan_state_t;

    // Register bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage : led_behavior_pkg

//--- touch_linked_led_behavior.sv
// LED behavior controller: trigger selection, four behaviors, sleep alternate
`timescale 1ns/1ps
`include "led_behavior_cfg.svh"

module touch_linked_led_behavior
    import led_behavior_pkg::*;
#(
    parameter int STEP_CYCLES = `STEP_CYCLES   // Cycles per 32 ms period count
) (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_arst_n,
    // Register port
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    // Touch status per sensor, 1 = touched
    input  wire logic [6:0]  i_touch,
    // LED pins, 1 = pin high
    output logic      [10:0] o_led
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    localparam int NCH = 11;            // LED channels
    reg_req_t    req;                   // Bundled bus request
    logic [7:0]  sensor_to_led_pairing; // Link bits
    logic [7:0]  led_behavior_low;      // LEDs 1-4 fields
    logic [7:0]  led_behavior_mid;      // LEDs 5-8 fields
    logic [7:0]  led_behavior_high;     // LEDs 9-11 plus sleep field
    logic [7:0]  pulse1_per;            // Pulse 1 period and start edge
    logic [7:0]  pulse2_per;            // Pulse 2 period
    logic [7:0]  breathe_per;           // Breathe period
    logic [7:0]  led_config;            // Pulse counts
    logic [10:0] light_drive_bit;       // Software drive bits
    logic [10:0] polarity;              // 1 = non-inverted (active high pin)
    logic [10:0] pin_is_input;          // Pin configured as input
    logic [2:0]  power_ctl;             // Option, sleep, deep sleep
    logic [10:0] active;                // Channel actuated
    logic [10:0] level;                 // Brightness above half, per channel

    assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

    // Register writes
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sensor_to_led_pairing <= `RST_ZERO;
            led_behavior_low      <= `RST_ZERO;
            led_behavior_mid      <= `RST_ZERO;
            led_behavior_high     <= `RST_ZERO;
            pulse1_per            <= `RST_PULSE1_PER;
            pulse2_per            <= `RST_PULSE2_PER;
            breathe_per           <= `RST_BREATHE_PER;
            led_config            <= `RST_LED_CONFIG;
            light_drive_bit       <= 11'h000;
            polarity              <= 11'h000;
            pin_is_input          <= 11'h000;
            power_ctl             <= 3'h0;
        end else if (req.wr) begin
            case (req.addr)
                `OFF_PAIRING:     sensor_to_led_pairing <= req.wdata;
                `OFF_BEHAV_LOW:   led_behavior_low      <= req.wdata;
                `OFF_BEHAV_MID:   led_behavior_mid      <= req.wdata;
                `OFF_BEHAV_HIGH:  led_behavior_high     <= req.wdata;
                `OFF_PULSE1_PER:  pulse1_per            <= req.wdata;
                `OFF_PULSE2_PER:  pulse2_per            <= {1'b0, req.wdata[6:0]};
                `OFF_BREATHE_PER: breathe_per           <= {1'b0, req.wdata[6:0]};
                `OFF_LED_CONFIG:  led_config            <= {2'b00, req.wdata[5:0]};
                `OFF_DRIVE_LOW:   light_drive_bit[7:0]  <= req.wdata;
                `OFF_DRIVE_HIGH:  light_drive_bit[10:8] <= req.wdata[2:0];
                `OFF_POL_LOW:     polarity[7:0]         <= req.wdata;
                `OFF_POL_HIGH:    polarity[10:8]        <= req.wdata[2:0];
                `OFF_INPUT_LOW:   pin_is_input[7:0]     <= req.wdata;
                `OFF_INPUT_HIGH:  pin_is_input[10:8]    <= req.wdata[2:0];
                `OFF_POWER_CTL:   power_ctl             <= req.wdata[2:0];
                default: ;                              // Unmapped writes dropped
            endcase
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `OFF_PAIRING:     o_rdata <= sensor_to_led_pairing;
                `OFF_BEHAV_LOW:   o_rdata <= led_behavior_low;
                `OFF_BEHAV_MID:   o_rdata <= led_behavior_mid;
                `OFF_BEHAV_HIGH:  o_rdata <= led_behavior_high;
                `OFF_PULSE1_PER:  o_rdata <= pulse1_per;
                `OFF_PULSE2_PER:  o_rdata <= pulse2_per;
                `OFF_BREATHE_PER: o_rdata <= breathe_per;
                `OFF_LED_CONFIG:  o_rdata <= led_config;
                `OFF_DRIVE_LOW:   o_rdata <= light_drive_bit[7:0];
                `OFF_DRIVE_HIGH:  o_rdata <= {5'h00, light_drive_bit[10:8]};
                `OFF_POL_LOW:     o_rdata <= polarity[7:0];
                `OFF_POL_HIGH:    o_rdata <= {5'h00, polarity[10:8]};
                `OFF_INPUT_LOW:   o_rdata <= pin_is_input[7:0];
                `OFF_INPUT_HIGH:  o_rdata <= {5'h00, pin_is_input[10:8]};
                `OFF_POWER_CTL:   o_rdata <= {5'h00, power_ctl};
                `OFF_ACTIVE_LOW:  o_rdata <= active[7:0];
                `OFF_ACTIVE_HIGH: o_rdata <= {5'h00, active[10:8]};
                default:          o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field selection
    logic [21:0] fields;                 // Normal fields, LED1 in low bits
    logic        sleeping;               // Power LED alternate in force
    assign fields   = {led_behavior_high[5:0], led_behavior_mid, led_behavior_low};
    assign sleeping = power_ctl[`POS_PWR_OPTION]
                      & (power_ctl[`POS_SLEEP] | power_ctl[`POS_DEEP_SLEEP_CTL]);

    // Pulse counts, code 0..7 gives 1..8 pulses
    logic [3:0] p1_count;
    logic [3:0] p2_count;
    assign p1_count = {1'b0, led_config[`POS_P1_CNT +: 3]} + 4'h1;
    assign p2_count = {1'b0, led_config[`POS_P2_CNT +: 3]} + 4'h1;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel engines
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            behavior_t   beh;            // Selected behavior
            logic        linked;         // Touch sensor is the source
            logic        trig;           // Current trigger level
            logic        trig_q;         // Trigger level last cycle
            logic        lit;            // Brightness above half this cycle
            logic        late;           // Second half of the current step
            logic        rise;           // Touch / set edge
            logic        fall;           // Release / clear edge
            chan_state_t state;          // Run state
            logic [6:0]  per;            // Selected period code
            logic [31:0] cyc;            // Cycles within one step
            logic [6:0]  step;           // Steps within one period
            logic [6:0]  nsteps;         // Steps per period, at least one
            logic [3:0]  pulses;         // Pulses left
            logic        period_end;     // Last cycle of a period

            // Behavior field, power LED swaps in its sleep field
            if (g == NCH - 1) begin : g_pwr
                assign beh = behavior_t'(sleeping ? led_behavior_high[`POS_SLEEP_ALT +: 2]
                                                  : fields[2*g +: 2]);
            end else begin : g_norm
                assign beh = behavior_t'(fields[2*g +: 2]);
            end

            // Only channels 0..6 have a paired sensor
            if (g < 7) begin : g_link
                assign linked = sensor_to_led_pairing[g];
                assign trig   = linked ? i_touch[g] : light_drive_bit[g];
            end else begin : g_nolink
                assign linked = 1'b0;
                assign trig   = light_drive_bit[g];
            end

            // A source switch compares the new source against the old level,
            // so an idle new source shows up as a release edge
            assign rise = trig & ~trig_q;
            assign fall = ~trig & trig_q;

            // Period code: zero and one both mean one step
            assign per    = (beh == BEH_PULSE1) ? pulse1_per[6:0]
                          : (beh == BEH_PULSE2) ? pulse2_per[6:0] : breathe_per[6:0];
            assign nsteps = (per == 7'h00) ? 7'h01 : per;
            assign period_end = (cyc == 32'(STEP_CYCLES - 1)) && (step == nsteps - 7'h01);

            // Trigger history
            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    trig_q   <= 1'b0;
                end else begin
                    trig_q   <= trig;
                end
            end

            // Behavior state machine
            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    state  <= ST_IDLE;
                    pulses <= 4'h0;
                end else if (pin_is_input[g]) begin
                    state  <= ST_IDLE;
                end else begin
                    case (state)
                        ST_IDLE: begin
                            // Pulse 1 starts on the chosen edge only
                            if (beh == BEH_PULSE1) begin
                                if (pulse1_per[`POS_ST_TRIG] ? fall : rise) begin
                                    state  <= ST_TAIL;
                                    pulses <= p1_count;
                                end
                            end else if (trig) begin
                                state <= ST_RUN;
                            end
                        end
                        ST_RUN: begin
                            // Direct and breathe follow the trigger at once
                            if (!trig && beh == BEH_PULSE2) begin
                                state  <= ST_TAIL;
                                pulses <= p2_count;
                            end else if (!trig) begin
                                state <= ST_IDLE;
                            end
                        end
                        ST_TAIL: begin
                            // Pulses run out regardless of the source
                            if (period_end) begin
                                if (pulses == 4'h1) begin
                                    state <= ST_DONE;
                                end
                                pulses <= pulses - 4'h1;
                            end
                        end
                        ST_DONE: begin
                            // Drive bit was ignored during the run; rearm
                            state <= ST_IDLE;
                        end
                        default: state <= ST_IDLE;
                    endcase
                end
            end

            // Period timing, restarted when a run begins or a held run is
            // released, so a counted tail is made of whole pulses
            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    cyc  <= 32'h0;
                    step <= 7'h00;
                end else if (state == ST_IDLE || state == ST_DONE || (state == ST_RUN && !trig)) begin
                    cyc  <= 32'h0;
                    step <= 7'h00;
                end else if (cyc == 32'(STEP_CYCLES - 1)) begin
                    cyc  <= 32'h0;
                    step <= (step >= nsteps - 7'h01) ? 7'h00 : step + 7'h01;
                end else begin
                    cyc  <= cyc + 32'h1;
                end
            end

            // Brightness: direct is full on; ramps lit in first half period,
            // counted in half steps so a one-step period still has a dark half
            assign late = (cyc >= 32'(STEP_CYCLES / 2));
            always_comb begin
                if (state == ST_IDLE || state == ST_DONE) begin
                    lit = 1'b0;
                end else if (beh == BEH_DIRECT) begin
                    lit = 1'b1;
                end else begin
                    lit = (({step, 1'b0} + {7'h00, late}) < {1'b0, nsteps});
                end
            end

            assign level[g] = lit;

            assign active[g] = (state != ST_IDLE) && (state != ST_DONE);

            // Pin level: polarity sets the idle state
            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    o_led[g] <= 1'b0;
                end else begin
                    o_led[g] <= level[g] ^ ~polarity[g];
                end
            end
        end
    endgenerate

endmodule : touch_linked_led_behavior

//--- led_behavior_sva.sv
// Port checker for the LED behavior block
`timescale 1ns/1ps
module led_behavior_sva
    import led_behavior_pkg::*;
#(
    parameter int STEP_CYCLES = 4   // Cycles per period count
) (
    // Clock, reset and register port
    input wire logic        i_core_clk,
    input wire logic        i_arst_n,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [7:0]  i_addr,
    input wire logic [7:0]  i_wdata,
    input wire logic [7:0]  o_rdata,
    // Sensors and pins
    input wire logic [6:0]  i_touch,
    input wire logic [10:0] o_led
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    logic [7:0]  sh [4];  // Link and behavior shadows
    logic [10:0] pol;     // Polarity shadow
    logic [10:0] inp;     // Input-pin shadow
    logic        drv0;    // Drive bit of light 1
    logic [3:0]  quiet;   // Cycles since last write, saturating
    logic        dir0;    // Light 1 is a direct output
    assign dir0 = !inp[0] && sh[1][1:0] == 2'h0;
    ////////////////////////////////////////
    // Shadow of what software wrote, cleared like the registers
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sh <= '{default: 8'h00};
            pol <= '0;
            inp <= '0;
            drv0 <= 1'b0;
        end else if (i_wr) begin
            case (i_addr)
                8'h80, 8'h81, 8'h82, 8'h83: sh[i_addr[1:0]] <= i_wdata;
                8'hA0: drv0 <= i_wdata[0];
                8'hA2: pol[7:0] <= i_wdata;
                8'hA3: pol[10:8] <= i_wdata[2:0];
                8'hA4: inp[7:0] <= i_wdata;
                8'hA5: inp[10:8] <= i_wdata[2:0];
                default: ;
            endcase
        end
    end
    // Settling counter: a_in_idle, a_dir_hold and a_touch_on judge pins only once writes have landed
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            quiet <= 4'h0;
        end else if (i_wr) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    ////////////////////////////////////////
    property p_rd_idle;
        !$past(i_rd) |-> o_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read");
    property p_unmapped;
        $past(i_rd) && $past(i_addr) == 8'h7F |-> o_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_link_rb;
        $past(i_rd) && $past(i_addr) == 8'h80 |-> o_rdata[6:0] == sh[0][6:0];
    endproperty
    a_link_rb: assert property (p_link_rb)
        else $error("link register readback wrong");
    property p_beh_rb;
        $past(i_rd) && $past(i_addr) inside {8'h81, 8'h82, 8'h83}
            |-> o_rdata == sh[$past(i_addr[1:0])];
    endproperty
    a_beh_rb: assert property (p_beh_rb)
        else $error("behavior register readback wrong");
    property p_in_idle;
        quiet == 4'hF |-> ((o_led ^ ~pol) & inp) == 11'h000;
    endproperty
    a_in_idle: assert property (p_in_idle)
        else $error("input pin not idle");
    property p_dir_hold;
        (quiet >= 4'h4 && dir0 && $stable(i_touch[0]))[*4]
            |-> o_led[0] == ((sh[0][0] ? i_touch[0] : drv0) ^ ~pol[0]);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("direct light 1 level wrong");
    property p_touch_on;
        quiet >= 4'h4 && dir0 && sh[0][0] && $rose(i_touch[0]) |-> ##[1:3] o_led[0] == pol[0];
    endproperty
    a_touch_on: assert property (p_touch_on)
        else $error("touch did not light linked light 1");
    property p_drive_on;
        dir0 && !sh[0][0] && $rose(drv0) |-> ##[1:3] o_led[0] == pol[0];
    endproperty
    a_drive_on: assert property (p_drive_on)
        else $error("drive bit did not light light 1");
    property p_unlink;
        i_wr && i_addr == 8'h80 && !i_wdata[0] && sh[0][0] && !drv0 && dir0
            |-> ##[1:4] o_led[0] == ~pol[0];
    endproperty
    a_unlink: assert property (p_unlink)
        else $error("unlink with clear drive bit not a release");
endmodule : led_behavior_sva

bind touch_linked_led_behavior led_behavior_sva #(.STEP_CYCLES(STEP_CYCLES)) led_behavior_sva_i (
    .i_core_clk(i_core_clk),
    .i_arst_n  (i_arst_n),
    .i_wr      (i_wr),
    .i_rd      (i_rd),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .o_rdata   (o_rdata),
    .i_touch   (i_touch),
    .o_led     (o_led)
);

//--- touch_panel_model.sv
// Touch sensor panel: reports finger presses, promptly or slowly
`timescale 1ns/1ps
module touch_panel_model (
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_arst_n,
    // Finger presses and slow-settle option
    input  wire logic [6:0] i_press,
    input  wire logic       i_slow,
    // Touch status toward the block
    output logic      [6:0] o_touch
);
    logic [6:0] stage [3];  // Settle pipeline
    // Slow sensors confirm a touch three cycles late
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stage <= '{default: 7'h00};
            o_touch <= 7'h00;
        end else begin
            stage[0] <= i_press;
            stage[1] <= stage[0];
            stage[2] <= stage[1];
            o_touch <= i_slow ? stage[2] : i_press;
        end
    end
endmodule : touch_panel_model

//--- tb.sv
// Self-checking bench for the LED behavior block
`timescale 1ns/1ps
module tb;
    import led_behavior_pkg::*;
    localparam int STEP = 4;  // Shortened period count
    localparam logic [7:0] RA [8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h88};
    localparam logic [7:0] RV [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h14, 8'h5D, 8'h24};
    localparam logic [7:0] PW [3] = '{8'h03, 8'h05, 8'h01};  // Sleep, deep sleep, awake
    logic        i_core_clk, i_arst_n, i_wr, i_rd, rd_seen, slow;
    logic [7:0]  i_addr, i_wdata, o_rdata, d;
    logic [6:0]  press, i_touch;
    logic [10:0] o_led;
    logic [7:0]  exp_q [$];  // Expected read data, oldest first
    int          n_mismatch, n_compared, seed, np, non, per;
    touch_linked_led_behavior #(.STEP_CYCLES(STEP)) touch_linked_led_behavior_i (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_wr(i_wr), .i_rd(i_rd),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_touch(i_touch), .o_led(o_led));
    touch_panel_model touch_panel_model_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
        .i_press(press), .i_slow(slow), .o_touch(i_touch));
    ////////////////////////////////////////
    task automatic check(string what, logic [10:0] seen, logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_core_clk);
        i_rd <= 1'b0;
    endtask : rd
    // Bounded wait for a pin level; giving up ends the run
    task automatic wait_led(int idx, logic v, int lim);
        for (int k = 0; k < lim && o_led[idx] !== v; k++) @(negedge i_core_clk);
        check("led level", o_led[idx], v);
        if (o_led[idx] !== v) final_report();
    endtask : wait_led
    // Counts lit pulses and lit cycles (polarity 0: lit means pin low)
    task automatic count(int idx, int w);
        logic last;
        np = 0;
        non = 0;
        last = o_led[idx];
        repeat (w) begin
            @(negedge i_core_clk);
            np += (last && !o_led[idx]);
            non += !o_led[idx];
            last = o_led[idx];
        end
    endtask : count
    ////////////////////////////////////////
    // Read data lands the cycle after the strobe; compare there
    always @(posedge i_core_clk) rd_seen <= i_rd;
    always @(negedge i_core_clk) begin
        if (rd_seen === 1'b1) begin
            check("rdata", o_rdata, exp_q.pop_front());
        end
    end
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    initial begin
        {i_arst_n, i_wr, i_rd, slow} = 4'h0;
        {i_addr, i_wdata, press} = '0;
        {n_mismatch, n_compared} = '0;
        seed = 32'hd9ef;
        repeat (4) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        for (int k = 0; k < 8; k++) rd(RA[k], RV[k]);
        for (int k = 0; k < 4; k++) begin
            d = 8'($random(seed)) & (k == 0 ? 8'h7F : 8'hFF);
            wr(8'h80 + 8'(k), d);
            rd(8'h80 + 8'(k), d);
        end
        for (int k = 0; k < 4; k++) wr(8'h80 + 8'(k), 8'h00);
        wr(8'h7F, 8'hFF);
        rd(8'h7F, 8'h00);
        // Unlinked direct light follows its drive bit and polarity
        wr(8'hA0, 8'h01);
        wait_led(0, 1'b0, 8);
        wr(8'hA0, 8'h00);
        wait_led(0, 1'b1, 8);
        wr(8'hA2, 8'h01);
        wait_led(0, 1'b0, 8);
        wr(8'hA2, 8'h00);
        // Each sensor lights only its own light, prompt and slow sensors alike
        wr(8'h80, 8'h7F);
        for (int n = 0; n < 7; n++) begin
            @(posedge i_core_clk);
            slow <= n[0];
            press <= 7'(1 << n);
            wait_led(n, 1'b0, 12);
            check("others idle", o_led | 11'(1 << n), 11'h7FF);
            @(posedge i_core_clk);
            press <= 7'h00;
            wait_led(n, 1'b1, 12);
        end
        // Source switches are judged on the new source
        @(posedge i_core_clk);
        press <= 7'h01;
        wait_led(0, 1'b0, 12);
        wr(8'h80, 8'h00);
        wait_led(0, 1'b1, 8);
        @(posedge i_core_clk);
        press <= 7'h00;
        wr(8'hA0, 8'h01);
        wait_led(0, 1'b0, 8);
        wr(8'h80, 8'h01);
        wait_led(0, 1'b1, 8);
        wr(8'h80, 8'h00);
        wr(8'hA0, 8'h00);
        // An input pin stays idle whatever its drive bit says
        wr(8'hA4, 8'h02);
        wr(8'hA0, 8'h02);
        repeat (20) @(negedge i_core_clk);
        check("input pin", o_led[1], 1'b1);
        wr(8'hA0, 8'h00);
        wr(8'hA4, 8'h00);
        // Counted pulses on light 3; a re-set mid-sequence is ignored
        wr(8'h81, 8'h10);
        for (int c = 0; c < 8; c++) begin
            per = (c == 0) ? 0 : (c == 7) ? 3 : 1;
            wr(8'h84, 8'(per));
            wr(8'h88, 8'(c));
            fork
                count(2, 120);
                begin
                    wr(8'hA0, 8'h04);
                    wr(8'hA0, 8'h00);
                    wr(8'hA0, 8'h04);
                end
            join
            check("pulses", 11'(np), 11'(c + 1));
            check("lit cycles", 11'(non), 11'((c + 1) * (per > 1 ? per : 1) * STEP / 2));
            wr(8'hA0, 8'h00);
        end
        // Held pulses on light 4, then a counted tail after release
        wr(8'h88, 8'h10);
        wr(8'h85, 8'h01);
        wr(8'h81, 8'h80);
        fork count(3, 40); wr(8'hA0, 8'h08); join
        check("held pulses", np >= 8, 1'b1);
        fork count(3, 40); wr(8'hA0, 8'h00); join
        check("tail pulses", np inside {3, 4}, 1'b1);
        check("tail end", o_led[3], 1'b1);
        // Breathing light 5 with an eight-cycle period
        wr(8'h86, 8'h02);
        wr(8'h82, 8'h03);
        fork count(4, 44); wr(8'hA0, 8'h10); join
        check("breaths", np inside {5, 6}, 1'b1);
        wr(8'hA0, 8'h00);
        wait_led(4, 1'b1, 16);
        // Power light breathes asleep, stays steady awake
        wr(8'h83, 8'hC0);
        for (int k = 0; k < 3; k++) begin
            fork
                count(10, 40);
                begin
                    wr(8'hA6, PW[k]);
                    wr(8'hA1, 8'h04);
                end
            join
            check("power light", np > 1, PW[k] != 8'h01);
            wr(8'hA1, 8'h00);
            wait_led(10, 1'b1, 16);
        end
        final_report();
    end
endmodule : tb
